// ---- verilog/jmb_pkg.sv ----
// Purpose: Shared constants and types of the multidrop scan bridge registers
// Assumes: Backplane test clock drives all scan logic
// Notes: Instruction codes are local choices; address codes are fixed

package jmb_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int JMB_IR_W = 8;                    // Instruction register length
	localparam int JMB_DR_W = 8;                    // Longest data register
	localparam int JMB_SLOT_W = 7;                  // Slot address inputs
	localparam int JMB_PORTS = 3;                   // Local scan ports

	// ----------------------------------------------------------------
	// Capture, address and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] JMB_IR_CAP_LSB = 2'h1;   // Low bits loaded on capture
	localparam logic [7:0] JMB_ADDR_LAST = 8'h3A;   // Highest single-bridge address
	localparam logic [7:0] JMB_ADDR_BCAST = 8'h3B;  // Broadcast address
	localparam logic [7:0] JMB_ADDR_GROUP = 8'h3C;  // Group address for code 00
	localparam logic [1:0] JMB_GROUP_RST = 2'h0;    // Group code after reset
	localparam logic [7:0] JMB_CFG_RST = 8'h01;     // Port configuration after reset

	// ----------------------------------------------------------------
	// Port configuration fields
	// ----------------------------------------------------------------
	localparam int JMB_CFG_TCK = 3;                 // Local clock behaviour bit
	localparam int JMB_CFG_LOOP = 4;                // Loopback chain select bit
	localparam int JMB_CFG_FLAG = 7;                // Read-only counter status bit

	// ----------------------------------------------------------------
	// Instruction codes
	// ----------------------------------------------------------------
	localparam logic [7:0] JMB_INS_BYPASS = 8'hFF;  // One-bit shortcut
	localparam logic [7:0] JMB_INS_SAMPLE = 8'h81;  // Pin sample chain
	localparam logic [7:0] JMB_INS_MODESEL = 8'h8E; // Port configuration register
	localparam logic [7:0] JMB_INS_GRPSEL = 8'h03;  // Group select register
	localparam logic [7:0] JMB_INS_GOWAIT = 8'hC3;  // Return to address wait

	// ----------------------------------------------------------------
	// Test access controller states
	// ----------------------------------------------------------------
	typedef enum logic [15:0] {
		JMB_TLR = 16'h0001,
		JMB_RTI = 16'h0002,
		JMB_SEL_DR = 16'h0004,
		JMB_CAP_DR = 16'h0008,
		JMB_SH_DR = 16'h0010,
		JMB_EX1_DR = 16'h0020,
		JMB_PA_DR = 16'h0040,
		JMB_EX2_DR = 16'h0080,
		JMB_UPD_DR = 16'h0100,
		JMB_SEL_IR = 16'h0200,
		JMB_CAP_IR = 16'h0400,
		JMB_SH_IR = 16'h0800,
		JMB_EX1_IR = 16'h1000,
		JMB_PA_IR = 16'h2000,
		JMB_EX2_IR = 16'h4000,
		JMB_UPD_IR = 16'h8000
	} jmb_tap_e;

endpackage

// ---- verilog/jmb_sync.sv ----
// Purpose: Two-flop level synchroniser, parameterised width
// Assumes: Each bit is an independent level or a slow toggle
// Notes: First stage is read only by the second stage

`timescale 1ns/1ps

module jmb_sync #(
	parameter int W = 1
) (
	input wire logic clk,          // Destination clock
	input wire logic rst,          // Synchronous reset, active high
	input wire logic [W-1:0] d,    // Asynchronous level in
	output logic [W-1:0] q         // Synchronised level out
);
	import jmb_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [W-1:0] s1;          // Metastability catcher
		logic [W-1:0] s2;          // Stable copy
	} jmb_sync_s;

	jmb_sync_s r;                  // Current state
	jmb_sync_s next_r;             // Next state

	// Shift the level through both stages
	always_comb begin
		next_r.s1 = d;
		next_r.s2 = r.s1;
	end

	// Register the stages
	always_ff @(posedge clk) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign q = r.s2;

endmodule

// ---- verilog/jmb_tap.sv ----
// Purpose: Backplane test access controller state machine
// Assumes: Standard sixteen-state sequence steered by the mode select pin
// Notes: Reset forces Test-Logic-Reset

`timescale 1ns/1ps

module jmb_tap (
	input wire logic tck,          // Backplane test clock
	input wire logic rst,          // Synchronous reset, active high
	input wire logic tms,          // Backplane mode select
	output jmb_pkg::jmb_tap_e state // Current controller state
);
	import jmb_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		jmb_tap_e st;              // Controller state
	} jmb_tap_s;

	jmb_tap_s r;                   // Current state
	jmb_tap_s next_r;              // Next state

	// Next controller state from mode select
	always_comb begin
		next_r = r;
		case (r.st)
			JMB_TLR: next_r.st = tms ? JMB_TLR : JMB_RTI;
			JMB_RTI: next_r.st = tms ? JMB_SEL_DR : JMB_RTI;
			JMB_SEL_DR: next_r.st = tms ? JMB_SEL_IR : JMB_CAP_DR;
			JMB_CAP_DR: next_r.st = tms ? JMB_EX1_DR : JMB_SH_DR;
			JMB_SH_DR: next_r.st = tms ? JMB_EX1_DR : JMB_SH_DR;
			JMB_EX1_DR: next_r.st = tms ? JMB_UPD_DR : JMB_PA_DR;
			JMB_PA_DR: next_r.st = tms ? JMB_EX2_DR : JMB_PA_DR;
			JMB_EX2_DR: next_r.st = tms ? JMB_UPD_DR : JMB_SH_DR;
			JMB_UPD_DR: next_r.st = tms ? JMB_SEL_DR : JMB_RTI;
			JMB_SEL_IR: next_r.st = tms ? JMB_TLR : JMB_CAP_IR;
			JMB_CAP_IR: next_r.st = tms ? JMB_EX1_IR : JMB_SH_IR;
			JMB_SH_IR: next_r.st = tms ? JMB_EX1_IR : JMB_SH_IR;
			JMB_EX1_IR: next_r.st = tms ? JMB_UPD_IR : JMB_PA_IR;
			JMB_PA_IR: next_r.st = tms ? JMB_EX2_IR : JMB_PA_IR;
			JMB_EX2_IR: next_r.st = tms ? JMB_UPD_IR : JMB_SH_IR;
			JMB_UPD_IR: next_r.st = tms ? JMB_SEL_DR : JMB_RTI;
			default: next_r.st = JMB_TLR;
		endcase
	end

	// Register the state
	always_ff @(posedge tck) begin
		if (rst) begin
			r.st <= JMB_TLR;
		end else begin
			r <= next_r;
		end
	end

	assign state = r.st;

endmodule

// ---- verilog/jmb_bridge.sv ----
// Purpose: Instruction, group, sample, shortcut and port configuration registers
// Assumes: Scan logic runs on the backplane test clock; status leaves on clk
// Notes: Shift on rising test clock, drive serial outputs on falling edge

`timescale 1ns/1ps

// Functional notes
// - Eight-bit instruction register shifts in Shift-IR
// - Capture-IR loads slot bits above 01
// - Address wait compares scanned address with slot
// - Codes 00 to 3A address single bridges
// - Address 3B selects every waiting bridge
// - Group address compared with two-bit group register
// - Group codes 00..11 map to 3C..3F
// - Test-Logic-Reset clears group register
// - Sample-only chain: enable, slots six..zero
// - One-bit shortcut register once selected
// - Port configuration resets to 00000001
// - Bits 0,1,2,4 chain; bit 3 clock (bit 3 is only stored and read back here, no clock logic uses it)
// - All ports parked: register only in chain
// - Unparked, loop bit clear: register, then chosen ports with pads
// - Bit 7 reads counter flag, ignores writes
// - Dedicated instruction accesses group register
module jmb_bridge (
	input wire logic clk,                          // System clock, 40 MHz
	input wire logic rst,                          // Synchronous reset, active high
	input wire logic tck_b,                        // Backplane test clock
	input wire logic tms_b,                        // Backplane mode select
	input wire logic tdi_b,                        // Backplane serial in
	output logic tdo_b,                            // Backplane serial out
	output logic tdo_b_oe,                         // Serial out drive enable
	input wire logic [jmb_pkg::JMB_SLOT_W-1:0] slot, // Hard-wired slot address pins
	input wire logic oe_n,                         // Local output enable pin, low active
	input wire logic all_parked,                   // Every local port parked
	input wire logic cntr_flag,                    // Test clock counter status
	input wire logic [jmb_pkg::JMB_PORTS-1:0] lsp_tdo, // Serial data back from ports
	output logic [jmb_pkg::JMB_PORTS-1:0] lsp_tdi, // Serial data out to ports
	output logic sel_out,                          // Bridge selected, on clk
	output logic [7:0] cfg_out                     // Port configuration, on clk
);
	import jmb_pkg::*;

	// ----------------------------------------------------------------
	// Input synchronisers into the test clock domain
	// ----------------------------------------------------------------
	logic rst_t;                                   // Reset seen by scan logic
	logic [JMB_SLOT_W-1:0] slot_s;                 // Synchronised slot pins
	logic oe_s;                                    // Synchronised enable pin
	logic parked_s;                                // Synchronised park status
	logic flag_s;                                  // Synchronised counter flag
	jmb_tap_e st;                                  // Controller state

	// Reset crossing, never itself reset
	jmb_sync #(.W(1)) u_rst_sync (
		.clk(tck_b),
		.rst(1'b0),
		.d(rst),
		.q(rst_t)
	);

	// Pins and slow status levels
	jmb_sync #(.W(JMB_SLOT_W + 3)) u_pin_sync (
		.clk(tck_b),
		.rst(rst_t),
		.d({slot, oe_n, all_parked, cntr_flag}),
		.q({slot_s, oe_s, parked_s, flag_s})
	);

	// Backplane controller
	jmb_tap u_tap (
		.tck(tck_b),
		.rst(rst_t),
		.tms(tms_b),
		.state(st)
	);

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	// Index of the input end of the active data register
	function automatic logic [2:0] dr_top(input logic [7:0] ins);
		case (ins)
			JMB_INS_SAMPLE: dr_top = 3'h7;
			JMB_INS_MODESEL: dr_top = 3'h7;
			JMB_INS_GRPSEL: dr_top = 3'h1;
			default: dr_top = 3'h0;
		endcase
	endfunction

	// Shift one bit into a register of the given length
	function automatic logic [7:0] shift_in(input logic [7:0] v, input logic [2:0] top,
		input logic b);
		logic [7:0] o;
		o = {1'b0, v[7:1]};
		o[top] = b;
		shift_in = o;
	endfunction

	// Address match in the address-wait state
	function automatic logic addr_hit(input logic [7:0] a, input logic [6:0] s,
		input logic [1:0] g);
		addr_hit = ((a <= JMB_ADDR_LAST) && (a == {1'b0, s}))
			|| (a == JMB_ADDR_BCAST)
			|| (a == (JMB_ADDR_GROUP + {6'h00, g}));
	endfunction

	// ----------------------------------------------------------------
	// Rising-edge scan state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] ir_sr;                         // Instruction shift stage
		logic [7:0] ins;                           // Active instruction
		logic sel;                                 // Bridge selected
		logic [1:0] grp;                           // Group select register
		logic [7:0] cfg;                           // Port configuration register
		logic [7:0] dr_sr;                         // Shared data shift stage
		logic [JMB_PORTS-1:0] pad;                 // Pad bits after each port
		logic tgl;                                 // Toggles on configuration update
	} jmb_tck_s;

	jmb_tck_s t;                                   // Current state
	jmb_tck_s next_t;                              // Next state

	// Register updates by controller state
	always_comb begin
		next_t = t;
		next_t.pad = lsp_tdo;
		case (st)
			// Reset values
			JMB_TLR: begin
				next_t.sel = 1'b0;
				next_t.ins = JMB_INS_BYPASS;
				next_t.grp = JMB_GROUP_RST;
				next_t.cfg = JMB_CFG_RST;
				next_t.tgl = ~t.tgl;
			end
			// Load slot bits above fixed pattern
			JMB_CAP_IR: begin
				next_t.ir_sr = {slot_s[5:0], JMB_IR_CAP_LSB};
			end
			// Instruction register in series
			JMB_SH_IR: begin
				next_t.ir_sr = shift_in(t.ir_sr, 3'h7, tdi_b);
			end
			// Select by address, or take new instruction
			JMB_UPD_IR: begin
				if (!t.sel) begin
					if (addr_hit(t.ir_sr, slot_s, t.grp)) begin
						next_t.sel = 1'b1;
						next_t.ins = JMB_INS_BYPASS;
					end
				end else begin
					next_t.ins = t.ir_sr;
					if (t.ir_sr == JMB_INS_GOWAIT) begin
						next_t.sel = 1'b0;
					end
				end
			end
			// Parallel capture into the data stage
			JMB_CAP_DR: begin
				case (t.ins)
					JMB_INS_SAMPLE: next_t.dr_sr = {oe_s, slot_s};
					JMB_INS_GRPSEL: next_t.dr_sr = {6'h00, t.grp};
					JMB_INS_MODESEL: next_t.dr_sr = {flag_s, t.cfg[6:0]};
					default: next_t.dr_sr = 8'h00;
				endcase
			end
			// Shift the selected data register
			JMB_SH_DR: begin
				if (t.sel) begin
					next_t.dr_sr = shift_in(t.dr_sr, dr_top(t.ins), tdi_b);
				end
			end
			// Parallel load only in the update state
			JMB_UPD_DR: begin
				if (t.sel && (t.ins == JMB_INS_GRPSEL)) begin
					next_t.grp = t.dr_sr[1:0];
				end
				if (t.sel && (t.ins == JMB_INS_MODESEL)) begin
					next_t.cfg = {1'b0, t.dr_sr[6:0]};
					next_t.tgl = ~t.tgl;
				end
			end
			default: begin
			end
		endcase
	end

	// Register rising-edge state
	always_ff @(posedge tck_b) begin
		if (rst_t) begin
			t <= '0;
			t.ins <= JMB_INS_BYPASS;
			t.cfg <= JMB_CFG_RST;
		end else begin
			t <= next_t;
		end
	end

	// ----------------------------------------------------------------
	// Falling-edge serial outputs and chain routing
	// ----------------------------------------------------------------
	typedef struct packed {
		logic tdo;                                 // Backplane serial out
		logic oe;                                  // Serial out enable
		logic [JMB_PORTS-1:0] local_scan_port;                 // Serial data to ports
	} jmb_neg_s;

	jmb_neg_s n;                                   // Current state
	jmb_neg_s next_n;                              // Next state
	logic shift_ir;                                // In Shift-IR
	logic shift_dr;                                // In Shift-DR
	logic reg_out;                                 // Output of selected register

	assign shift_ir = (st == JMB_SH_IR);
	assign shift_dr = (st == JMB_SH_DR);
	assign reg_out = shift_ir ? t.ir_sr[0] : t.dr_sr[0];

	// Route register, then enabled ports each followed by a pad
	always_comb begin
		logic link;
		link = reg_out;
		next_n = n;
		if (shift_dr && !parked_s && !t.cfg[JMB_CFG_LOOP]) begin
			for (int i = 0; i < JMB_PORTS; i++) begin
				if (t.cfg[i]) begin
					next_n.local_scan_port[i] = link;
					link = t.pad[i];
				end
			end
		end
		next_n.tdo = link;
		next_n.oe = t.sel && (shift_ir || shift_dr);
	end

	// Drive serial outputs on the falling edge
	always_ff @(negedge tck_b) begin
		if (rst_t) begin
			n <= '0;
		end else begin
			n <= next_n;
		end
	end

	assign tdo_b = n.tdo;
	assign tdo_b_oe = n.oe;
	assign lsp_tdi = n.local_scan_port;

	// ----------------------------------------------------------------
	// Status into the system clock domain
	// ----------------------------------------------------------------
	logic sel_c;                                   // Selected level on clk
	logic tgl_c;                                   // Update toggle on clk

	jmb_sync #(.W(2)) u_stat_sync (
		.clk(clk),
		.rst(rst),
		.d({t.sel, t.tgl}),
		.q({sel_c, tgl_c})
	);

	typedef struct packed {
		logic sel;                                 // Selected copy
		logic [7:0] cfg;                           // Configuration copy
		logic tgl;                                 // Last toggle seen
	} jmb_clk_s;

	jmb_clk_s c;                                   // Current state
	jmb_clk_s next_c;                              // Next state

	// Take the stable configuration when its toggle arrives
	always_comb begin
		next_c = c;
		next_c.sel = sel_c;
		next_c.tgl = tgl_c;
		if (tgl_c != c.tgl) begin
			next_c.cfg = t.cfg;
		end
	end

	// Register system-side copies
	always_ff @(posedge clk) begin
		if (rst) begin
			c <= '0;
			c.cfg <= JMB_CFG_RST;
		end else begin
			c <= next_c;
		end
	end

	assign sel_out = c.sel;
	assign cfg_out = c.cfg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	ir_shift_a: assert property (@(posedge tck_b) disable iff (rst_t)
		shift_ir |=> t.ir_sr == {$past(tdi_b), $past(t.ir_sr[7:1])})
		else $error("instruction shift wrong");
	ir_capture_a: assert property (@(posedge tck_b) disable iff (rst_t)
		st == JMB_CAP_IR |=> t.ir_sr == {$past(slot_s[5:0]), JMB_IR_CAP_LSB})
		else $error("instruction capture wrong");
	bcast_sel_a: assert property (@(posedge tck_b) disable iff (rst_t)
		(st == JMB_UPD_IR && !t.sel && t.ir_sr == JMB_ADDR_BCAST) |=> t.sel)
		else $error("broadcast did not select");
	group_sel_a: assert property (@(posedge tck_b) disable iff (rst_t)
		(st == JMB_UPD_IR && !t.sel && t.ir_sr == JMB_ADDR_GROUP + {6'h00, t.grp})
		|=> t.sel)
		else $error("group address did not select");
	no_match_a: assert property (@(posedge tck_b) disable iff (rst_t)
		(st == JMB_UPD_IR && !t.sel && t.ir_sr != {1'b0, slot_s} && t.ir_sr != JMB_ADDR_BCAST
		&& t.ir_sr != {JMB_ADDR_GROUP[7:2], t.grp}) |=> !t.sel)
		else $error("selected without match");
	reset_regs_a: assert property (@(posedge tck_b) disable iff (rst_t)
		st == JMB_TLR |=> (t.grp == JMB_GROUP_RST) && (t.cfg == JMB_CFG_RST))
		else $error("reset values wrong");
	sample_order_a: assert property (@(posedge tck_b) disable iff (rst_t)
		(st == JMB_CAP_DR && t.ins == JMB_INS_SAMPLE) |=> t.dr_sr == {$past(oe_s), $past(slot_s)})
		else $error("sample chain order wrong");
	flag_read_a: assert property (@(posedge tck_b) disable iff (rst_t)
		(st == JMB_CAP_DR && t.ins == JMB_INS_MODESEL) |=> t.dr_sr[7] == $past(flag_s)
		&& t.cfg[JMB_CFG_FLAG] == 1'b0)
		else $error("counter flag bit wrong");
	parked_route_a: assert property (@(posedge tck_b) disable iff (rst_t)
		(shift_dr && parked_s) |-> next_n.tdo == reg_out)
		else $error("parked chain not direct");

endmodule

// ---- sim/jmb_master.sv ----
// Purpose: Behavioural backplane test master driving the bridge's scan pins
// Assumes: Test clock stands low between operations, 160 ns period
// Notes: Inputs change just after the falling edge, output sampled at the rising edge

`timescale 1ns/1ps

module jmb_master (
	output logic tck_b,         // Backplane test clock
	output logic tms_b,         // Mode select
	output logic tdi_b,         // Serial data to the bridge
	input wire logic tdo_b,     // Serial data from the bridge
	input wire logic tdo_b_oe   // Bridge drives serial out
);
	logic idle_bit; // Toggles so an idle data line never looks stable

	initial begin
		tck_b = 1'b0;
		tms_b = 1'b1;
		tdi_b = 1'b0;
		idle_bit = 1'b0;
	end

	// ----------------------------------------------------------------
	// One test clock period; serial out is read at the rising edge
	// ----------------------------------------------------------------
	task automatic step(input logic m, input logic d, output logic o);
		#1;
		tms_b = m;
		tdi_b = d;
		#79;
		o = tdo_b_oe ? tdo_b : 1'bx; // Undriven output reads unknown
		tck_b = 1'b1;
		#80;
		tck_b = 1'b0;
	endtask

	// Controller move with no data of interest
	task automatic nav(input logic m);
		logic o;
		idle_bit = ~idle_bit;
		step(m, idle_bit, o);
	endtask

	// Five mode-select highs reach Test-Logic-Reset, then park in idle
	task automatic reset5();
		repeat (5) nav(1'b1);
		nav(1'b0);
	endtask

	// Full scan from idle back to idle, n bits LSB first
	task automatic scan(input logic ir, input int n, input logic [15:0] din,
		output logic [15:0] dout);
		logic o;
		dout = '0;
		nav(1'b1);
		if (ir) begin
			nav(1'b1);
		end
		nav(1'b0);
		nav(1'b0);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], o);
			dout[i] = o;
		end
		nav(1'b1);
		nav(1'b0);
	endtask
endmodule

// ---- sim/jmb_bridge_tb_top.sv ----
// Purpose: Self-checking bench for the scan bridge registers
// Assumes: Local ports are modelled as zero-length loops
// Notes: Every scenario is a task that drives and judges on its own

`timescale 1ns/1ps

module jmb_bridge_tb_top;
	import jmb_pkg::*;

	localparam logic [6:0] SLOT = 7'h15; // Below the group codes
	logic clk, rst, tck_b, tms_b, tdi_b, tdo_b, tdo_b_oe, oe_n, all_parked, cntr_flag, sel_out;
	logic [6:0] slot;                    // Hard-wired slot value
	logic [2:0] lsp_tdo, lsp_tdi;        // Local port loops
	logic [7:0] cfg_out;                 // Exported configuration
	logic [15:0] d;                      // Data returned by a scan
	int n_errors, n_tests;               // Mismatches and comparisons

	assign lsp_tdo = lsp_tdi;

	jmb_bridge i_jmb_bridge (.clk(clk), .rst(rst), .tck_b(tck_b), .tms_b(tms_b),
		.tdi_b(tdi_b), .tdo_b(tdo_b), .tdo_b_oe(tdo_b_oe), .slot(slot), .oe_n(oe_n),
		.all_parked(all_parked), .cntr_flag(cntr_flag), .lsp_tdo(lsp_tdo),
		.lsp_tdi(lsp_tdi), .sel_out(sel_out), .cfg_out(cfg_out));

	jmb_master i_jmb_master (.tck_b(tck_b), .tms_b(tms_b), .tdi_b(tdi_b),
		.tdo_b(tdo_b), .tdo_b_oe(tdo_b_oe));

	// ----------------------------------------------------------------
	// Clock and helpers
	// ----------------------------------------------------------------
	always #12.5 clk = ~clk;

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic give_verdict();
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Bounded wait for a clk-side output to reach a value
	task automatic settle(input logic is_cfg, input logic [7:0] exp);
		int k;
		k = 0;
		while (k < 40 && (is_cfg ? cfg_out : {7'h00, sel_out}) !== exp) begin
			@(posedge clk);
			k++;
		end
		if (k == 40) begin
			check("wait", is_cfg ? cfg_out : {7'h00, sel_out}, exp);
			give_verdict();
		end
	endtask

	task automatic ir(input logic [7:0] c);
		i_jmb_master.scan(1'b1, 8, {8'h00, c}, d);
	endtask

	task automatic dr(input int n, input logic [15:0] v);
		i_jmb_master.scan(1'b0, n, v, d);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// Single addressing boundary, mismatch, capture pattern, deselect
	task automatic t_address();
		ir(JMB_ADDR_LAST);
		settle(1'b0, 8'h00);
		check("sel_mismatch", sel_out, 1'b0);
		ir({1'b0, SLOT});
		settle(1'b0, 8'h01);
		check("sel_slot", sel_out, 1'b1);
		ir(JMB_INS_GOWAIT);
		check("ir_capture", d, {SLOT[5:0], 2'b01});
		settle(1'b0, 8'h00);
		check("sel_gowait", sel_out, 1'b0);
	endtask

	// Broadcast then the one-bit shortcut with every port parked
	task automatic t_broadcast();
		ir(JMB_ADDR_BCAST);
		settle(1'b0, 8'h01);
		check("sel_bcast", sel_out, 1'b1);
		dr(2, 16'h0001);
		check("shortcut", d, 16'h0002);
		ir(JMB_INS_GOWAIT);
	endtask

	// Each group code written by slot, read back, then group addressed
	task automatic t_groups();
		for (int g = 0; g < 4; g++) begin
			ir({1'b0, SLOT});
			ir(JMB_INS_GRPSEL);
			dr(2, 16'(g));
			dr(2, 16'(g));
			check("group_read", d, 16'(g));
			ir(JMB_INS_GOWAIT);
			settle(1'b0, 8'h00);
			ir(JMB_ADDR_GROUP + 8'((g + 1) % 4));
			settle(1'b0, 8'h00);
			check("group_miss", sel_out, 1'b0);
			ir(JMB_ADDR_GROUP + 8'(g));
			settle(1'b0, 8'h01);
			check("group_hit", sel_out, 1'b1);
			ir(JMB_INS_GOWAIT);
			settle(1'b0, 8'h00);
		end
	endtask

	// Configuration write, read-only flag, port chains, sample chain
	task automatic t_config();
		ir({1'b0, SLOT});
		ir(JMB_INS_MODESEL);
		check("ir_capture_sel", d, {SLOT[5:0], 2'b01});
		dr(8, 16'h00FA);
		check("cfg_capture", d, {8'h00, 1'b1, JMB_CFG_RST[6:0]});
		settle(1'b1, 8'h7A);
		check("cfg_flag_ro", cfg_out, 8'h7A);
		@(posedge clk);
		#2 all_parked = 1'b0;
		dr(8, 16'h0005);
		check("cfg_reread", d, 16'h00FA);
		settle(1'b1, 8'h05);
		dr(10, {6'h00, 8'h02, 2'b00});
		check("chain_p0_p2", d[9:2], 8'h85);
		dr(9, {7'h00, 8'h10, 1'b0});
		check("chain_p1", d[8:1], 8'h82);
		dr(8, 16'h0010);
		check("loopback", d, 16'h0090);
		@(posedge clk);
		#2 all_parked = 1'b1;
		dr(8, 16'h0005);
		check("parked_len", d, 16'h0090);
		dr(8, 16'h0005);
		check("parked_chain", d, 16'h0085);
		ir(JMB_INS_SAMPLE);
		dr(8, 16'h0000);
		check("sample", d, {8'h00, oe_n, SLOT});
	endtask

	// Test-Logic-Reset restores group and configuration
	task automatic t_tlr();
		i_jmb_master.reset5();
		settle(1'b1, JMB_CFG_RST);
		check("cfg_tlr", cfg_out, JMB_CFG_RST);
		ir(JMB_ADDR_GROUP);
		settle(1'b0, 8'h01);
		check("group_tlr", sel_out, 1'b1);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		slot = SLOT;
		oe_n = 1'b1;
		all_parked = 1'b1;
		cntr_flag = 1'b1;
		n_errors = 0;
		n_tests = 0;
		fork
			begin
				repeat (12) @(posedge clk);
				#2 rst = 1'b0;
			end
			i_jmb_master.reset5();
		join
		i_jmb_master.reset5();
		check("sel_rst", sel_out, 1'b0);
		check("cfg_rst", cfg_out, JMB_CFG_RST);
		t_address();
		t_broadcast();
		t_groups();
		t_config();
		t_tlr();
		give_verdict();
	end
endmodule
